// file: src/dtc_pkg.sv
// Purpose: shared constants and state types for the dual timer control registers
// Assumes: APB slave with 32-bit data; each register sits in one aligned word
// Notes: register indices are word numbers; byte address is four times the index
package dtc_pkg;

  // apb geometry
  localparam int          ADDR_W         = 18;
  localparam int          IDX_W          = 16;
  localparam int          DATA_W         = 32;

  // register indices (byte address = index * 4)
  localparam logic [15:0] T0_CTRL_IDX    = 16'hff30;
  localparam logic [15:0] T1_CTRL_IDX    = 16'hff31;
  localparam logic [15:0] T0_RLD_LO_IDX  = 16'hff32;

  // control register field positions
  localparam int          CTL_EXT_CLK    = 0;
  localparam int          CTL_LOAD_NOW   = 1;
  localparam int          CTL_RUN        = 2;
  localparam int          CTL_CLK_OUT    = 3;

  // reset values
  localparam logic [7:0]  RLD_RESET      = 8'hff;
  localparam logic        CTL_BIT_RESET  = 1'b0;
  localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;

  // per-timer control state
  typedef struct packed {
    logic clk_out_en;
    logic run;
    logic ext_clk_sel;
    logic load_now;
  } dtc_tmr_t;

  // bus slave and reload state
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  reload;
  } dtc_bus_t;

endpackage

// file: src/dtc_regs.sv
// Purpose: apb register block for two programmable timers and timer 0 low reload byte
// Assumes: single clock pclk; apb master holds the request until pready is seen
// Notes: every access has one wait state; unmapped or unaligned access returns pslverr
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// R1: each timer has a read/write clock output enable bit, reset to 0.
// R2: each timer has a read/write run bit; 1 counts, 0 halts; reset 0.
// R3: each timer has an input clock select bit; 1 external, 0 internal; reset 0.
// R4: timer 0 low reload byte is read/write, resets to all ones, bit 7 msb.
// R5: writing 1 to preset loads the counter; 0 does nothing; reads as 0.
module dtc_regs (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [dtc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [dtc_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                  pstrb,
  output      logic [dtc_pkg::DATA_W-1:0]  prdata,
  output      logic                        pready,
  output      logic                        pslverr,
  // timer 0 controls
  output      logic                        t0_clk_out_en,
  output      logic                        t0_run,
  output      logic                        t0_ext_clk_sel,
  output      logic                        t0_load_now,
  output      logic [7:0]                  t0_reload_low,
  // timer 1 controls
  output      logic                        t1_clk_out_en,
  output      logic                        t1_run,
  output      logic                        t1_ext_clk_sel,
  output      logic                        t1_load_now
);

  dtc_pkg::dtc_bus_t            st_reg;
  dtc_pkg::dtc_bus_t            st_next;

  logic [dtc_pkg::IDX_W-1:0]    idx;
  logic                         aligned;
  logic                         rd_req;
  logic [1:0]                   hit_ctl;
  logic                         hit_rld;
  logic                         hit_any;
  logic                         done;
  logic                         wr_lo;
  logic [1:0]                   wr_ctl;
  logic [1:0]                   clk_out_v;
  logic [1:0]                   run_v;
  logic [1:0]                   ext_v;
  logic [1:0]                   load_v;
  logic [7:0]                   ctl_rd [2];
  logic [7:0]                   rd_byte;

  // address decode
  assign idx        = paddr[dtc_pkg::ADDR_W-1:2];
  assign aligned    = (paddr[1:0] == 2'b00);
  assign hit_ctl[0] = aligned && (idx == dtc_pkg::T0_CTRL_IDX);
  assign hit_ctl[1] = aligned && (idx == dtc_pkg::T1_CTRL_IDX);
  assign hit_rld    = aligned && (idx == dtc_pkg::T0_RLD_LO_IDX);
  assign hit_any    = hit_ctl[0] || hit_ctl[1] || hit_rld;
  assign rd_req     = psel && penable && !st_reg.pready && !pwrite;

  // completing edge of an access: pready already high
  assign done  = psel && penable && st_reg.pready;
  assign wr_lo = done && pwrite && pstrb[0] && hit_any;

  // per-timer control registers
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tmr
      assign wr_ctl[gi] = wr_lo && hit_ctl[gi];
      dtc_timer_ctrl u_ctrl (
        .pclk        (pclk),
        .presetn     (presetn),
        .wr_en       (wr_ctl[gi]),
        .wdata       (pwdata[7:0]),
        .clk_out_en  (clk_out_v[gi]),
        .run         (run_v[gi]),
        .ext_clk_sel (ext_v[gi]),
        .load_now    (load_v[gi]),
        .rdata       (ctl_rd[gi])
      );
    end
  endgenerate

  // readback mux
  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctl[0]) begin
      rd_byte = ctl_rd[0];
    end else if (hit_ctl[1]) begin
      rd_byte = ctl_rd[1];
    end else if (hit_rld) begin
      rd_byte = st_reg.reload; // [R4]
    end
  end

  // bus sequencing and reload byte
  always_comb begin
    st_next = st_reg;
    if (psel && penable && !st_reg.pready) begin
      st_next.pready  = 1'b1;
      st_next.pslverr = !hit_any;
      st_next.prdata  = {24'h00_0000, rd_byte};
    end else if (st_reg.pready) begin
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.prdata  = dtc_pkg::RDATA_RESET;
    end
    if (wr_lo && hit_rld) begin
      st_next.reload = pwdata[7:0]; // [R4]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.pready  <= 1'b0;
      st_reg.pslverr <= 1'b0;
      st_reg.prdata  <= dtc_pkg::RDATA_RESET;
      st_reg.reload  <= dtc_pkg::RLD_RESET; // [R4]
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign prdata         = st_reg.prdata;
  assign pready         = st_reg.pready;
  assign pslverr        = st_reg.pslverr;
  assign t0_reload_low  = st_reg.reload;
  assign t0_clk_out_en  = clk_out_v[0];
  assign t0_run         = run_v[0];
  assign t0_ext_clk_sel = ext_v[0];
  assign t0_load_now    = load_v[0];
  assign t1_clk_out_en  = clk_out_v[1];
  assign t1_run         = run_v[1];
  assign t1_ext_clk_sel = ext_v[1];
  assign t1_load_now    = load_v[1];

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  clk_out_follows_a: assert property ( // [R1]
    wr_ctl[0] |=> t0_clk_out_en == $past(pwdata[dtc_pkg::CTL_CLK_OUT]))
    else $error("timer 0 clock output enable did not follow the written bit");

  clk_out_hold_a: assert property ( // [R1]
    !wr_ctl[1] |=> $stable(t1_clk_out_en))
    else $error("timer 1 clock output enable changed without a write");

  run_bit_a: assert property ( // [R2]
    wr_ctl[1] |=> t1_run == $past(pwdata[2]))
    else $error("timer 1 run bit did not follow the written value");

  run_readback_a: assert property ( // [R2]
    (psel && penable && !pready && !pwrite && hit_ctl[0]) |=>
      pready && (prdata[2] == t0_run) && (prdata[7:4] == 4'h0))
    else $error("timer 0 run bit read back wrong");

  ext_sel_a: assert property ( // [R3]
    wr_ctl[0] |=> t0_ext_clk_sel == $past(pwdata[0]))
    else $error("timer 0 clock select did not follow the written value");

  reload_write_a: assert property ( // [R4]
    (wr_lo && hit_rld) |=> t0_reload_low == $past(pwdata[7:0]))
    else $error("reload byte did not take the written value");

  reload_hold_a: assert property ( // [R4]
    !(wr_lo && hit_rld) |=> $stable(t0_reload_low))
    else $error("reload byte changed without a write");

  preset_pulse_a: assert property ( // [R5]
    (wr_ctl[1] && pwdata[1]) |=> t1_load_now ##1 !t1_load_now)
    else $error("timer 1 preset did not give a single pulse");

  preset_no_spur_a: assert property ( // [R5]
    !(wr_ctl[0] && pwdata[1]) |=> !t0_load_now)
    else $error("timer 0 preset pulsed without a write of one");

  preset_reads_zero_a: assert property ( // [R5]
    pready |-> !prdata[1] || !($past(hit_ctl[0]) || $past(hit_ctl[1])))
    else $error("preset bit read back as one");

  bus_answer_a: assert property (
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("pready not a single cycle after one wait state");

  unmapped_err_a: assert property (
    (psel && penable && !pready && !hit_any) |=> pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped access not answered with an error");

  clk_out_t1_a: assert property ( // [R1]
    wr_ctl[1] |=> t1_clk_out_en == $past(pwdata[dtc_pkg::CTL_CLK_OUT]))
    else $error("timer 1 clock output enable did not follow the written bit");

  clk_out_hold_t0_a: assert property ( // [R1]
    !wr_ctl[0] |=> $stable(t0_clk_out_en))
    else $error("timer 0 clock output enable changed without a write");

  clk_out_rd_t0_a: assert property ( // [R1]
    (rd_req && hit_ctl[0]) |=> prdata[dtc_pkg::CTL_CLK_OUT] == t0_clk_out_en)
    else $error("timer 0 clock output enable read back wrong");

  clk_out_rd_t1_a: assert property ( // [R1]
    (rd_req && hit_ctl[1]) |=> prdata[dtc_pkg::CTL_CLK_OUT] == t1_clk_out_en)
    else $error("timer 1 clock output enable read back wrong");

  run_t0_a: assert property ( // [R2]
    wr_ctl[0] |=> t0_run == $past(pwdata[dtc_pkg::CTL_RUN]))
    else $error("timer 0 run bit did not follow the written value");

  run_hold_t0_a: assert property ( // [R2]
    !wr_ctl[0] |=> $stable(t0_run))
    else $error("timer 0 run bit changed without a write");

  run_hold_t1_a: assert property ( // [R2]
    !wr_ctl[1] |=> $stable(t1_run))
    else $error("timer 1 run bit changed without a write");

  run_rd_t1_a: assert property ( // [R2]
    (rd_req && hit_ctl[1]) |=>
      (prdata[dtc_pkg::CTL_RUN] == t1_run) && (prdata[7:4] == 4'h0))
    else $error("timer 1 run bit read back wrong");

  run_isolated_a: assert property ( // [R2]
    wr_ctl[0] |=>
      $stable(t1_run) && $stable(t1_clk_out_en) && $stable(t1_ext_clk_sel))
    else $error("timer 1 controls changed on a timer 0 write");

  ext_t1_a: assert property ( // [R3]
    wr_ctl[1] |=> t1_ext_clk_sel == $past(pwdata[dtc_pkg::CTL_EXT_CLK]))
    else $error("timer 1 clock select did not follow the written value");

  ext_hold_t0_a: assert property ( // [R3]
    !wr_ctl[0] |=> $stable(t0_ext_clk_sel))
    else $error("timer 0 clock select changed without a write");

  ext_hold_t1_a: assert property ( // [R3]
    !wr_ctl[1] |=> $stable(t1_ext_clk_sel))
    else $error("timer 1 clock select changed without a write");

  ext_rd_t0_a: assert property ( // [R3]
    (rd_req && hit_ctl[0]) |=> prdata[dtc_pkg::CTL_EXT_CLK] == t0_ext_clk_sel)
    else $error("timer 0 clock select read back wrong");

  ext_rd_t1_a: assert property ( // [R3]
    (rd_req && hit_ctl[1]) |=> prdata[dtc_pkg::CTL_EXT_CLK] == t1_ext_clk_sel)
    else $error("timer 1 clock select read back wrong");

  reload_rd_a: assert property ( // [R4]
    (rd_req && hit_rld) |=> prdata == {24'h00_0000, t0_reload_low})
    else $error("reload byte read back wrong");

  reload_msb_a: assert property ( // [R4]
    (wr_lo && hit_rld) |=> t0_reload_low[7] == $past(pwdata[7]))
    else $error("reload byte msb not taken from data bit 7");

  reload_lane_a: assert property ( // [R4]
    (done && pwrite && !pstrb[0]) |=> $stable(t0_reload_low))
    else $error("reload byte written with lane 0 strobe low");

  err_no_write_a: assert property ( // [R4]
    (done && pwrite && !hit_any) |=>
      $stable(t0_reload_low) && $stable(t0_run) && $stable(t1_run))
    else $error("refused write changed a register");

  preset_pulse_t0_a: assert property ( // [R5]
    (wr_ctl[0] && pwdata[dtc_pkg::CTL_LOAD_NOW]) |=> t0_load_now ##1 !t0_load_now)
    else $error("timer 0 preset did not give a single pulse");

  preset_no_spur_t1_a: assert property ( // [R5]
    !(wr_ctl[1] && pwdata[dtc_pkg::CTL_LOAD_NOW]) |=> !t1_load_now)
    else $error("timer 1 preset pulsed without a write of one");

  preset_cross_a: assert property ( // [R5]
    wr_ctl[0] |=> !t1_load_now)
    else $error("timer 1 preset pulsed on a timer 0 write");

  rd_upper_zero_a: assert property (
    pready |-> (prdata[31:8] == 24'h00_0000))
    else $error("read data upper bits not zero");

  rd_idle_zero_a: assert property (
    !pready |-> (prdata == 32'h0000_0000) && !pslverr)
    else $error("read data or error shown outside an answer");

  mapped_ok_a: assert property (
    (psel && penable && !pready && hit_any) |=> !pslverr)
    else $error("mapped access answered with an error");

  unaligned_err_a: assert property (
    (psel && penable && !pready && (paddr[1:0] != 2'b00)) |=> pslverr)
    else $error("unaligned access not answered with an error");

  ready_idle_a: assert property (
    !(psel && penable) |=> !pready)
    else $error("pready raised outside an access phase");

  preset_write_c: cover property (wr_ctl[0] && pwdata[1] ##1 t0_load_now);
  reload_read_c:  cover property (done && !pwrite && hit_rld);
  unmapped_c:     cover property (pready && pslverr);
  run_both_c:     cover property (t0_run && t1_run);

endmodule

// file: src/dtc_timer_ctrl.sv
// Purpose: control bits of one programmable timer
// Assumes: wr_en is a one-cycle strobe at the completing bus edge
// Notes: load_now is a one-cycle pulse; it never reads back as set
`timescale 1ns/1ps
module dtc_timer_ctrl (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // register write
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  // timer controls
  output      logic       clk_out_en,
  output      logic       run,
  output      logic       ext_clk_sel,
  output      logic       load_now,
  // readback
  output      logic [7:0] rdata
);

  dtc_pkg::dtc_tmr_t st_reg;
  dtc_pkg::dtc_tmr_t st_next;

  always_comb begin
    st_next          = st_reg;
    st_next.load_now = 1'b0;
    if (wr_en) begin
      st_next.clk_out_en  = wdata[dtc_pkg::CTL_CLK_OUT];  // [R1]
      st_next.run         = wdata[dtc_pkg::CTL_RUN];      // [R2]
      st_next.ext_clk_sel = wdata[dtc_pkg::CTL_EXT_CLK];  // [R3]
      st_next.load_now    = wdata[dtc_pkg::CTL_LOAD_NOW]; // [R5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.clk_out_en  <= dtc_pkg::CTL_BIT_RESET; // [R1]
      st_reg.run         <= dtc_pkg::CTL_BIT_RESET; // [R2]
      st_reg.ext_clk_sel <= dtc_pkg::CTL_BIT_RESET; // [R3]
      st_reg.load_now    <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign clk_out_en  = st_reg.clk_out_en;
  assign run         = st_reg.run;
  assign ext_clk_sel = st_reg.ext_clk_sel;
  assign load_now    = st_reg.load_now;

  // preset bit and unused upper bits read as zero
  always_comb begin
    rdata                        = 8'h00;
    rdata[dtc_pkg::CTL_CLK_OUT]  = st_reg.clk_out_en;
    rdata[dtc_pkg::CTL_RUN]      = st_reg.run;
    rdata[dtc_pkg::CTL_EXT_CLK]  = st_reg.ext_clk_sel;
    rdata[dtc_pkg::CTL_LOAD_NOW] = 1'b0; // [R5]
  end

endmodule

// file: test/dtc_regs_tb.sv
// Purpose: self-checking bench for the dual timer control register block
// Assumes: apb master driven on rising edges; one clock pclk at 200 MHz
// Notes: pready and answers are taken at rising edges; outputs checked at falling edges, the first reset values at a rising edge
`timescale 1ns/1ps
module testbench;
  logic                       pclk;
  logic                       presetn;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [dtc_pkg::ADDR_W-1:0] paddr;
  logic [dtc_pkg::DATA_W-1:0] pwdata;
  logic [3:0]                 pstrb;
  logic [dtc_pkg::DATA_W-1:0] prdata;
  logic                       pready;
  logic                       pslverr;
  logic                       t0_clk_out_en;
  logic                       t0_run;
  logic                       t0_ext_clk_sel;
  logic                       t0_load_now;
  logic [7:0]                 t0_reload_low;
  logic                       t1_clk_out_en;
  logic                       t1_run;
  logic                       t1_ext_clk_sel;
  logic                       t1_load_now;
  logic [31:0]                rd;
  logic                       er;
  int                         err_total;
  int                         checks;

  dtc_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .t0_clk_out_en(t0_clk_out_en), .t0_run(t0_run),
    .t0_ext_clk_sel(t0_ext_clk_sel), .t0_load_now(t0_load_now),
    .t0_reload_low(t0_reload_low), .t1_clk_out_en(t1_clk_out_en), .t1_run(t1_run),
    .t1_ext_clk_sel(t1_ext_clk_sel), .t1_load_now(t1_load_now));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic end_of_test();
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [17:0] ba(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  // one apb transfer; starts after a rising edge, holds the request until pready
  // is sampled high at a rising edge, takes the answer there and then releases
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    if (n >= 50) begin
      err_total++;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d}, 4'h1);
  endtask

  task automatic rdchk(input string name, input logic [17:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    check(name, rd, exp);
  endtask

  initial begin
    #20000;
    err_total++;
    end_of_test();
  end

  initial begin
    err_total = 0;
    checks    = 0;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = '0;
    pwdata    = '0;
    pstrb     = 4'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("t0 outs", {t0_clk_out_en, t0_run, t0_load_now, t0_ext_clk_sel}, 4'h0);
    check("t1 outs", {t1_clk_out_en, t1_run, t1_load_now, t1_ext_clk_sel}, 4'h0);
    check("reload port", t0_reload_low, 8'hff);
    rdchk("t0 ctrl", ba(dtc_pkg::T0_CTRL_IDX), 32'h0000_0000);
    rdchk("t1 ctrl", ba(dtc_pkg::T1_CTRL_IDX), 32'h0000_0000);
    rdchk("reload", ba(dtc_pkg::T0_RLD_LO_IDX), 32'h0000_00ff);
    // all ones: preset pulses once, reads back clear, upper bits read 0
    wr(ba(dtc_pkg::T0_CTRL_IDX), 8'hff);
    @(negedge pclk);
    check("t0 outs set", {t0_clk_out_en, t0_run, t0_load_now, t0_ext_clk_sel}, 4'hf);
    @(negedge pclk);
    check("t0 pulse end", t0_load_now, 1'b0);
    rdchk("t0 ctrl", ba(dtc_pkg::T0_CTRL_IDX), 32'h0000_000d);
    wr(ba(dtc_pkg::T0_CTRL_IDX), 8'h00);
    @(negedge pclk);
    check("t0 outs clr", {t0_clk_out_en, t0_run, t0_load_now, t0_ext_clk_sel}, 4'h0);
    // one bit at a time on timer 1
    for (int b = 0; b < 4; b++) begin
      wr(ba(dtc_pkg::T1_CTRL_IDX), 8'h01 << b);
      @(negedge pclk);
      check("t1 outs", {t1_clk_out_en, t1_run, t1_load_now, t1_ext_clk_sel}, 4'h1 << b);
      check("t0 untouched", {t0_clk_out_en, t0_run, t0_ext_clk_sel}, 3'h0);
      rdchk("t1 ctrl", ba(dtc_pkg::T1_CTRL_IDX), (b == 1) ? 32'h0 : (32'h1 << b));
    end
    // reload byte, msb and lsb set
    wr(ba(dtc_pkg::T0_RLD_LO_IDX), 8'h81);
    @(negedge pclk);
    check("reload port", t0_reload_low, 8'h81);
    rdchk("reload", ba(dtc_pkg::T0_RLD_LO_IDX), 32'h0000_0081);
    // lane 0 strobe low: ignored
    apb(1'b1, ba(dtc_pkg::T0_RLD_LO_IDX), 32'h0000_0042, 4'he);
    check("strobe err", er, 1'b0);
    rdchk("reload", ba(dtc_pkg::T0_RLD_LO_IDX), 32'h0000_0081);
    // unmapped and unaligned accesses
    apb(1'b0, ba(16'hff33), 32'h0, 4'h0);
    check("unmapped err", er, 1'b1);
    check("unmapped data", rd, 32'h0000_0000);
    apb(1'b1, ba(dtc_pkg::T0_RLD_LO_IDX) + 18'h1, 32'h0000_0011, 4'h1);
    check("unaligned err", er, 1'b1);
    rdchk("reload", ba(dtc_pkg::T0_RLD_LO_IDX), 32'h0000_0081);
    // both timers running at once
    wr(ba(dtc_pkg::T0_CTRL_IDX), 8'h04);
    wr(ba(dtc_pkg::T1_CTRL_IDX), 8'h0c);
    @(negedge pclk);
    check("both run", {t0_run, t1_run, t1_clk_out_en}, 3'h7);
    // mid-run reset restores defaults
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("reload rst", t0_reload_low, 8'hff);
    check("t1 rst", {t1_clk_out_en, t1_run, t1_load_now, t1_ext_clk_sel}, 4'h0);
    check("t0 rst", {t0_clk_out_en, t0_run, t0_load_now, t0_ext_clk_sel}, 4'h0);
    rdchk("t1 ctrl rst", ba(dtc_pkg::T1_CTRL_IDX), 32'h0000_0000);
    end_of_test();
  end
endmodule
